// File: hdl/servo_seq_consts.vh
`ifndef SERVO_SEQ_CONSTS_VH
`define SERVO_SEQ_CONSTS_VH
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_WAIT        8'h08
`define REG_RUN_DLY     8'h0c
`define REG_STALL_DLY   8'h10
`define REG_REL_SPD     8'h14
`define REG_STOP_TIME   8'h18
`define REG_CLR_TIME    8'h1c
`define REG_SPEED       8'h20
// Control fields
`define CTRL_ALM_SEQ    1:0
`define CTRL_OFF_SEQ    3:2
`define CTRL_DEC_SEQ    4
`define CTRL_RST        32'h0000_0000
// Reset values of settings (ms, except REL_SPD_RST in r/min)
`define WAIT_MS_RST     16'd1500
`define RUN_DLY_RST     16'd500
`define STALL_DLY_RST   16'd0
`define REL_SPD_RST     16'd30
`define STOP_TIME_RST   16'd500
`define CLR_TIME_RST    16'd120
// Timing
`define CLK_MHZ         200
`define MS_CYCLES       (`CLK_MHZ * 1000)
`define ON_SPEED_RPM    16'd30
`define STOP_SPEED_RPM  16'd1
`endif

// File: hdl/servo_enable_brake_sequencer.v
// Operation
// [RL1] Refuse commands during power-up term
// [RL2] Ready needs init done and main power
// [RL3] Protection active about 1.5 s after init
// [RL4] Protection delay set by wait time
// [RL5] Servo-on status means enable accepted only
// [RL6] Running brake delay ends early at low speed
// [RL7] Alarm at stall: brake delay zero
// [RL8] Alarm drives dynamic brake per sequence
// [RL9] Long running delay waits for off state
// [RL10] Host advised: running delay equals stop time
// [RL11] Alarm clear held for recognition time
// [RL12] Standstill servo-off uses stall brake delay
// [RL13] Servo-off dynamic brake per sequence setting
// [RL14] Servo-on waits until speed below 30 r/min
// [RL15] Reassert while decelerating waits for stop
// [RL16] Decel energization per servo-off decel setting
// [RL17] Brake output drops at delay end
// [RL18] Host stops motor before servo-off normally
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "servo_seq_consts.vh"
module servo_enable_brake_sequencer #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Drive inputs
  input  wire        init_done,
  input  wire        main_power,
  input  wire        servo_enable_input,
  input  wire        alarm_clear_input,
  input  wire        alarm_event,
  input  wire [15:0] motor_speed,
  // Drive outputs
  output reg         servo_ready_output,
  output reg         servo_on_status_output,
  output reg         brake_release_output,
  output reg         motor_energized,
  output reg         dynamic_brake,
  output reg         protect_active,
  output reg         cmd_accept,
  output reg         alarm_active
);

  localparam ST_OFF   = 3'd0;
  localparam ST_ON    = 3'd1;
  localparam ST_BRAKE = 3'd2;
  localparam ST_DECEL = 3'd3;
  localparam ST_ALARM = 3'd4;

  reg [31:0] ctrl_q;
  reg [15:0] wait_q;
  reg [15:0] run_dly_q;
  reg [15:0] stall_dly_q;
  reg [15:0] rel_spd_q;
  reg [15:0] stop_time_q;
  reg [15:0] clr_time_q;
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [17:0] pre_q;
  reg        ms_tick;
  reg [15:0] up_ms_q;
  reg [15:0] dly_ms_q;
  reg [15:0] dly_lim_q;
  reg        dly_early_q;
  reg        dly_run_q;
  reg [15:0] clr_ms_q;
  reg        clr_done_q;
  reg        brk_wait_off_q;

  reg        aw_have_q;
  reg        w_have_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  wire stalled = motor_speed < `STOP_SPEED_RPM;
  wire slow    = motor_speed < `ON_SPEED_RPM;
  wire dly_end = (dly_ms_q >= dly_lim_q) || dly_early_q;

  // Merge byte lanes into a 16-bit setting
  function [15:0] wr16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // AXI write: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl_q       <= `CTRL_RST;
      wait_q       <= `WAIT_MS_RST;
      run_dly_q    <= `RUN_DLY_RST;
      stall_dly_q  <= `STALL_DLY_RST;
      rel_spd_q    <= `REL_SPD_RST;
      stop_time_q  <= `STOP_TIME_RST;
      clr_time_q   <= `CLR_TIME_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr_q)
          `REG_CTRL: begin
            if (w_strb_q[0]) begin
              ctrl_q[7:0] <= w_data_q[7:0];
            end
          end
          `REG_WAIT:      wait_q      <= wr16(wait_q, w_data_q, w_strb_q);
          `REG_RUN_DLY:   run_dly_q   <= wr16(run_dly_q, w_data_q, w_strb_q);
          `REG_STALL_DLY: stall_dly_q <= wr16(stall_dly_q, w_data_q, w_strb_q);
          `REG_REL_SPD:   rel_spd_q   <= wr16(rel_spd_q, w_data_q, w_strb_q);
          `REG_STOP_TIME: stop_time_q <= wr16(stop_time_q, w_data_q, w_strb_q);
          `REG_CLR_TIME:  clr_time_q  <= wr16(clr_time_q, w_data_q, w_strb_q);
          `REG_STATUS, `REG_SPEED: s_axi_bresp <= 2'b00;
          default:        s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end

  // AXI read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `REG_CTRL:      s_axi_rdata <= {24'h000000, ctrl_q[7:0]};
        `REG_STATUS:    s_axi_rdata <= {21'h000000, state_q, alarm_active, cmd_accept,
                                        protect_active, dynamic_brake, motor_energized,
                                        brake_release_output, servo_on_status_output,
                                        servo_ready_output};
        `REG_WAIT:      s_axi_rdata <= {16'h0000, wait_q};
        `REG_RUN_DLY:   s_axi_rdata <= {16'h0000, run_dly_q};
        `REG_STALL_DLY: s_axi_rdata <= {16'h0000, stall_dly_q};
        `REG_REL_SPD:   s_axi_rdata <= {16'h0000, rel_spd_q};
        `REG_STOP_TIME: s_axi_rdata <= {16'h0000, stop_time_q};
        `REG_CLR_TIME:  s_axi_rdata <= {16'h0000, clr_time_q};
        `REG_SPEED:     s_axi_rdata <= {16'h0000, motor_speed};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Millisecond timebase shared by all delays
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q   <= 18'd0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (pre_q == MS_CYCLES[17:0] - 18'd1);
      pre_q   <= (pre_q == MS_CYCLES[17:0] - 18'd1) ? 18'd0 : pre_q + 18'd1;
    end
  end

  // Power-up term counts from reset release; protection follows the wait setting
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_ms_q        <= 16'd0;
      protect_active <= 1'b0;
      servo_ready_output <= 1'b0;
    end else begin
      if (ms_tick && !protect_active) begin
        up_ms_q <= up_ms_q + 16'd1;
      end
      if (up_ms_q >= wait_q) begin
        protect_active <= 1'b1; // see [RL3] see [RL4]
      end
      servo_ready_output <= init_done && main_power; // see [RL2]
    end
  end

  // Alarm clear needs the input held for the recognition time
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_ms_q   <= 16'd0;
      clr_done_q <= 1'b0;
    end else begin
      clr_done_q <= 1'b0;
      if (!alarm_clear_input) begin
        clr_ms_q <= 16'd0;
      end else if (clr_ms_q >= clr_time_q) begin
        clr_done_q <= 1'b1; // see [RL11]
        clr_ms_q   <= 16'd0;
      end else if (ms_tick) begin
        clr_ms_q <= clr_ms_q + 16'd1;
      end
    end
  end

  // Sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        // Activation also held off until the motor is slow
        if (alarm_event) begin
          state_d = ST_ALARM; // see [RL8]
        end else if (servo_enable_input && protect_active && servo_ready_output && slow) begin
          state_d = ST_ON; // see [RL1] see [RL14]
        end
      end
      ST_ON: begin
        if (alarm_event) begin
          state_d = ST_ALARM;
        end else if (!servo_enable_input) begin
          state_d = ST_BRAKE;
        end
      end
      ST_BRAKE: begin
        if (alarm_event) begin
          state_d = ST_ALARM;
        end else if (dly_end) begin
          state_d = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (alarm_event) begin
          state_d = ST_ALARM;
        end else if (stalled) begin
          state_d = ST_OFF; // see [RL15]
        end
      end
      ST_ALARM: begin
        // Clearing only lands in off; re-enable goes through the normal entry
        if (clr_done_q && !alarm_event) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= ST_OFF;
      dly_run_q      <= 1'b0;
      dly_ms_q       <= 16'd0;
      dly_lim_q      <= 16'd0;
      dly_early_q    <= 1'b0;
      brk_wait_off_q <= 1'b0;
      brake_release_output <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ms_tick) begin
        dly_ms_q <= dly_ms_q + 16'd1;
      end
      // Speed cut-off only ends a delay begun in motion, else the stall delay is lost
      if (dly_run_q && (motor_speed < rel_spd_q)) begin
        dly_early_q <= 1'b1; // see [RL6]
      end
      if (state_q == ST_ON) begin
        brake_release_output <= 1'b1;
        dly_ms_q       <= 16'd0;
        dly_early_q    <= 1'b0;
        brk_wait_off_q <= 1'b0;
        dly_run_q      <= !stalled; // see [RL12]
        if (state_d == ST_BRAKE) begin
          dly_lim_q   <= stalled ? stall_dly_q : run_dly_q; // see [RL12] see [RL6]
        end else if (state_d == ST_ALARM) begin
          dly_lim_q      <= stalled ? 16'd0 : run_dly_q; // see [RL7]
          brk_wait_off_q <= !stalled && (run_dly_q > stop_time_q); // see [RL9]
        end
      end else if (state_q == ST_ALARM && state_d == ST_OFF) begin
        brake_release_output <= 1'b0;
      end else if ((state_q == ST_BRAKE || state_q == ST_ALARM) && !brk_wait_off_q && dly_end) begin
        brake_release_output <= 1'b0; // see [RL17] see [RL9]
      end else if (state_q == ST_DECEL || state_q == ST_OFF) begin
        brake_release_output <= 1'b0;
      end
    end
  end

  // Outputs that follow the state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on_status_output <= 1'b0;
      motor_energized        <= 1'b0;
      dynamic_brake          <= 1'b0;
      cmd_accept             <= 1'b0;
      alarm_active           <= 1'b0;
    end else begin
      servo_on_status_output <= (state_d == ST_ON); // see [RL5]
      cmd_accept   <= (state_d == ST_ON) && protect_active; // see [RL1]
      alarm_active <= (state_d == ST_ALARM);
      case (state_d)
        ST_ON: begin
          motor_energized <= 1'b1;
          dynamic_brake   <= 1'b0;
        end
        ST_BRAKE, ST_DECEL: begin
          motor_energized <= ctrl_q[`CTRL_DEC_SEQ]; // see [RL16]
          dynamic_brake   <= (state_d == ST_DECEL) ? ctrl_q[2] : ctrl_q[3]; // see [RL13]
        end
        ST_ALARM: begin
          motor_energized <= 1'b0;
          dynamic_brake   <= |ctrl_q[`CTRL_ALM_SEQ]; // see [RL8]
        end
        default: begin
          motor_energized <= 1'b0;
          dynamic_brake   <= ctrl_q[2];
        end
      endcase
    end
  end

endmodule

// File: tb/servo_seq_checker.sv
`timescale 1ns/10ps
`include "servo_seq_consts.vh"
module servo_seq_checker #(
  parameter MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Drive inputs
  input wire logic        init_done,
  input wire logic        main_power,
  input wire logic        servo_enable_input,
  input wire logic        alarm_clear_input,
  input wire logic [15:0] motor_speed,
  // Drive outputs
  input wire logic        servo_ready_output,
  input wire logic        servo_on_status_output,
  input wire logic        brake_release_output,
  input wire logic        motor_energized,
  input wire logic        protect_active,
  input wire logic        cmd_accept,
  input wire logic        alarm_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Alarm raised while the shaft is still
  sequence stall_alarm;
    $rose(alarm_active) && motor_speed == 16'd0;
  endsequence
  // Small slack for the registered brake output
  sequence brake_set_soon;
    ##[0:2] !brake_release_output;
  endsequence
  ready_follow_a: assert property (init_done && main_power |=> servo_ready_output)
    else $error("ready did not follow init and power");
  ready_drop_a: assert property (!(init_done && main_power) |=> !servo_ready_output)
    else $error("ready stayed high without init or power");
  protect_hold_a: assert property (protect_active |=> protect_active)
    else $error("protection dropped");
  cmd_gate_a: assert property (cmd_accept |-> servo_on_status_output && protect_active)
    else $error("commands accepted too early");
  on_slow_a: assert property ($rose(servo_on_status_output) |->
    $past(motor_speed) < `ON_SPEED_RPM) else $error("servo on at high speed");
  on_enable_a: assert property ($rose(servo_on_status_output) |->
    $past(servo_enable_input) && protect_active) else $error("servo on without enable");
  stall_brake_a: assert property (stall_alarm |-> brake_set_soon)
    else $error("brake late on stall alarm");
  alarm_off_a: assert property (alarm_active |-> !servo_on_status_output && !cmd_accept)
    else $error("servo on during alarm");
  clear_held_a: assert property ($fell(alarm_active) |->
    $past(alarm_clear_input, 2) && $past(alarm_clear_input, 8)) else $error("short clear");
  on_energ_a: assert property (servo_on_status_output |-> motor_energized)
    else $error("servo on but not energized");
endmodule

bind servo_enable_brake_sequencer servo_seq_checker #(.MS_CYCLES(MS_CYCLES)) chk (.*);

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Requests from the bench
  input  wire logic on_req,
  input  wire logic clr_req,
  // Discrete servo I/O
  output logic      servo_enable_input,
  output logic      alarm_clear_input
);
  // Registered so the drive never sees a level change near its edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_enable_input <= 1'b0;
      alarm_clear_input <= 1'b0;
    end else begin
      servo_enable_input <= on_req;
      alarm_clear_input <= clr_req;
    end
  end
endmodule

// File: tb/servo_enable_brake_sequencer_test.sv
`timescale 1ns/10ps
`include "servo_seq_consts.vh"
module servo_enable_brake_sequencer_test;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic init_done = 1'b1, main_power = 1'b0, alarm_event = 1'b0;
  logic on_req = 1'b0, clr_req = 1'b0, servo_enable_input, alarm_clear_input;
  logic [15:0] motor_speed = 16'd100;
  logic servo_ready_output, servo_on_status_output, brake_release_output;
  logic motor_energized, dynamic_brake, protect_active, cmd_accept, alarm_active;
  int n_mismatch = 0, n_checks = 0;
  logic [7:0] ra [7] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [7] = '{32'h0, 32'h5dc, 32'h1f4, 32'h0, 32'h1e, 32'h1f4, 32'h78};

  always #2.5 clk = ~clk;

  // One ms is ten cycles here so the delays stay short
  servo_enable_brake_sequencer #(.MS_CYCLES(10)) dut (.*);
  host_model host (.*);

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_checks++;
      if (g !== e) begin
        n_mismatch++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Ends just after an edge so the bench samples settled outputs
  task cyc(input int n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  // Readys are sampled at the falling edge; they cannot move before the next rise
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(negedge clk);
        ta = s_axi_awvalid & s_axi_awready;
        tw = s_axi_wvalid & s_axi_wready;
        tb = s_axi_bvalid;
        rb = s_axi_bresp;
        @(posedge clk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      #1;
    end
  endtask

  task rdr(input logic [7:0] a);
    logic ta, tr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(negedge clk);
        ta = s_axi_arvalid & s_axi_arready;
        tr = s_axi_rvalid;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge clk);
        if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
      #1;
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end

  initial begin
    cyc(4);
    rst_n <= 1'b1;
    on_req <= 1'b1;
    cyc(2);
    chk("ready", 0, servo_ready_output);
    for (int i = 0; i < 7; i++) begin
      rdr(ra[i]);
      chk("reset value", rv[i], rd);
    end
    rdr(8'h40);
    chk("unmapped resp", 2, rr);
    chk("unmapped data", 0, rd);
    wr(8'h40, 32'h0);
    chk("unmapped wr resp", 2, rb);
    wr(`REG_WAIT, 32'h8);
    chk("write resp", 0, rb);
    chk("cmd early", 0, cmd_accept);
    chk("protect early", 0, protect_active);
    main_power <= 1'b1;
    cyc(3);
    chk("ready", 1, servo_ready_output);
    wr(`REG_CTRL, 32'h0d);
    wr(`REG_RUN_DLY, 32'h3);
    wr(`REG_STOP_TIME, 32'h3);
    wr(`REG_CLR_TIME, 32'h2);
    cyc(90);
    chk("protect", 1, protect_active);
    chk("on fast", 0, servo_on_status_output);
    motor_speed <= 16'd0;
    cyc(6);
    chk("on", 1, servo_on_status_output);
    chk("cmd", 1, cmd_accept);
    chk("brake rel", 1, brake_release_output);
    alarm_event <= 1'b1;
    cyc(6);
    chk("alarm", 1, alarm_active);
    chk("stall brake", 0, brake_release_output);
    chk("alarm db", 1, dynamic_brake);
    alarm_event <= 1'b0;
    clr_req <= 1'b1;
    cyc(8);
    clr_req <= 1'b0;
    cyc(4);
    chk("short clear", 1, alarm_active);
    clr_req <= 1'b1;
    cyc(30);
    clr_req <= 1'b0;
    cyc(6);
    chk("cleared", 0, alarm_active);
    chk("on again", 1, servo_on_status_output);
    wr(`REG_STALL_DLY, 32'h3);
    on_req <= 1'b0;
    cyc(6);
    chk("stall brake held", 1, brake_release_output);
    cyc(40);
    chk("stall off brake", 0, brake_release_output);
    chk("off db", 1, dynamic_brake);
    on_req <= 1'b1;
    cyc(6);
    motor_speed <= 16'd200;
    cyc(2);
    on_req <= 1'b0;
    cyc(6);
    chk("run brake held", 1, brake_release_output);
    chk("decel energ", 0, motor_energized);
    on_req <= 1'b1;
    cyc(40);
    chk("run brake", 0, brake_release_output);
    chk("on moving", 0, servo_on_status_output);
    motor_speed <= 16'd0;
    cyc(6);
    chk("on stopped", 1, servo_on_status_output);
    motor_speed <= 16'd200;
    cyc(2);
    on_req <= 1'b0;
    cyc(4);
    motor_speed <= 16'd10;
    cyc(6);
    chk("early brake", 0, brake_release_output);
    wr(`REG_RUN_DLY, 32'h5);
    on_req <= 1'b1;
    motor_speed <= 16'd0;
    cyc(6);
    chk("on for alarm", 1, servo_on_status_output);
    motor_speed <= 16'd200;
    cyc(2);
    alarm_event <= 1'b1;
    cyc(70);
    chk("run alarm brake", 1, brake_release_output);
    alarm_event <= 1'b0;
    clr_req <= 1'b1;
    cyc(30);
    clr_req <= 1'b0;
    cyc(6);
    chk("alarm off brake", 0, brake_release_output);
    chk("off fast", 0, servo_on_status_output);
    end_sim;
  end
endmodule
